// ==== src/ddrc_pkg.sv ====
// Shared constants and types of the DDR read calibration and ECC front end
package ddrc_pkg;

	// ************************************************************
	// Bus map
	// ************************************************************
	localparam logic [31:0] REG_BASE = 32'h1000_0000;
	localparam logic [31:0] MEM_BASE = 32'h2000_0000;
	localparam logic [31:0] MAP_STD_BYTES = 32'h2000_0000;
	localparam logic [31:0] MAP_EXT_BYTES = 32'h4000_0000;
	localparam logic [3:0] OFF_CFG = 4'h0;
	localparam logic [3:0] OFF_DLY = 4'h4;
	localparam logic [3:0] OFF_STAT = 4'h8;
	localparam logic [3:0] OFF_CTRL = 4'hc;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CFG_LANE = 0;
	localparam int CFG_BURST = 1;
	localparam int CFG_ECC = 2;
	localparam int CFG_COR_FWD = 3;
	localparam int CFG_ERR_FWD = 4;
	localparam int CFG_EXT = 5;
	localparam int CFG_W = 6;
	localparam logic [5:0] CFG_RST = 6'h00;
	localparam int STAT_INIT_DONE = 0;
	localparam int STAT_AT_MAX = 1;
	localparam int STAT_COR = 2;
	localparam int STAT_UNCOR = 3;
	localparam int CTRL_INIT = 0;
	localparam int DLY_SLOT = 8;
	localparam int LANES = 2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEM = 3'b010,
		ST_RESP = 3'b100
	} ddrc_state_t;

endpackage : ddrc_pkg

// ==== src/ddrc_ecc_if.sv ====
// Carrier between the controller and the ECC codec
`timescale 1ns/1ps
`default_nettype none
interface ddrc_ecc_if (
	input wire logic clk,
	input wire logic rst
);
	logic [15:0] enc_data;
	logic [31:0] enc_word;
	logic [31:0] dec_word;
	logic [15:0] dec_data;
	logic dec_single;
	logic dec_double;
	modport codec(input clk, rst, enc_data, dec_word,
		output enc_word, dec_data, dec_single, dec_double);
	modport ctrl(input enc_word, dec_data, dec_single, dec_double,
		output enc_data, dec_word);
endinterface : ddrc_ecc_if
`default_nettype wire

// ==== src/ddrc_ecc_codec.sv ====
// SEC-DED codec: two data bytes, each with its check byte on the other lane
`timescale 1ns/1ps
`default_nettype none
module ddrc_ecc_codec (
	ddrc_ecc_if.codec e // Data and check words
);

	// Hamming parities {p8,p4,p2,p1} over one byte
	function automatic logic [3:0] hpar(input logic [7:0] d);
		hpar = {^d[7:4], d[1] ^ d[2] ^ d[3] ^ d[7],
			d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6], d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
	endfunction : hpar

	// Syndrome to data bit; parity positions need no data fix
	function automatic logic [7:0] flip(input logic [3:0] s);
		case (s)
			4'h3: flip = 8'h01;
			4'h5: flip = 8'h02;
			4'h6: flip = 8'h04;
			4'h7: flip = 8'h08;
			4'h9: flip = 8'h10;
			4'ha: flip = 8'h20;
			4'hb: flip = 8'h40;
			4'hc: flip = 8'h80;
			default: flip = 8'h00;
		endcase
	endfunction : flip

	logic [1:0] sgl;
	logic [1:0] dbl;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_byte
			logic [7:0] d;
			logic [7:0] rd;
			logic [7:0] rc;
			logic [3:0] syn;
			logic ov;
			assign d = e.enc_data[8*g +: 8];
			assign e.enc_word[16*g +: 8] = d;
			assign e.enc_word[16*g+8 +: 8] = {3'h0, ^d ^ ^hpar(d), hpar(d)};
			assign rd = e.dec_word[16*g +: 8];
			assign rc = e.dec_word[16*g+8 +: 8];
			assign syn = rc[3:0] ^ hpar(rd);
			assign ov = ^rd ^ ^rc[4:0];
			assign sgl[g] = ov;
			assign dbl[g] = ~ov & (|syn);
			assign e.dec_data[8*g +: 8] = rd ^ (ov ? flip(syn) : 8'h00);
		end
	endgenerate

	assign e.dec_single = |sgl;
	assign e.dec_double = |dbl;

	AST_ECC_CLASS: assert property (@(posedge e.clk) disable iff (e.rst)
		(e.dec_word[15:0] == {3'h0, ^e.dec_data[7:0] ^ ^hpar(e.dec_data[7:0]),
			hpar(e.dec_data[7:0]), e.dec_data[7:0]}) |-> !sgl[0] && !dbl[0])
		else $error("clean byte flagged as faulty");
	AST_ECC_LAYOUT: assert property (@(posedge e.clk) disable iff (e.rst)
		e.enc_word[7:0] == e.enc_data[7:0] && e.enc_word[23:16] == e.enc_data[15:8]
		&& e.enc_word[15:13] == 3'h0 && e.enc_word[31:29] == 3'h0)
		else $error("data and check lanes misplaced");

endmodule : ddrc_ecc_codec
`default_nettype wire

// ==== src/ddrc_dly_bank.sv ====
// Per-lane read strobe delay fields
`timescale 1ns/1ps
`default_nettype none
module ddrc_dly_bank #(
	parameter int LANES = 2,
	parameter int DLY_W = 6
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic wr_i, // Write the selected fields
	input wire logic [LANES-1:0] sel_i, // Lane select
	input wire logic [8*LANES-1:0] wdata_i, // One byte slot per lane
	output logic [DLY_W*LANES-1:0] dly_o, // Delays, lane 0 lowest
	output logic at_max_o // Some lane sits at its limit
);

	logic [LANES-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// Drives the sampling point straight away, so the next read sees it
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					dly_o[DLY_W*g +: DLY_W] <= '0;
				end else if (wr_i && sel_i[g]) begin
					dly_o[DLY_W*g +: DLY_W] <= wdata_i[8*g +: DLY_W];
				end
			end
			assign hit[g] = &dly_o[DLY_W*g +: DLY_W];
		end
	endgenerate

	assign at_max_o = |hit;

endmodule : ddrc_dly_bank
`default_nettype wire

// ==== src/ddrc_ctrl.sv ====
// DDR front end: register file, read window delays, ECC path, bus memory window
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ddrc_ctrl #(
	parameter int DLY_W = 6
) (
	input wire logic clk_i, // 50 MHz system clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [31:0] adr_i, // Wishbone byte address
	input wire logic [31:0] dat_i, // Wishbone write data
	output logic [31:0] dat_o, // Wishbone read data
	input wire logic [3:0] sel_i, // Wishbone byte selects
	input wire logic we_i, // Wishbone write
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	output logic ack_o, // Wishbone acknowledge
	output logic err_o, // Wishbone error
	output logic mem_init_o, // Start memory initialization
	input wire logic mem_init_done_i, // Memory sequencer finished
	output logic mem_req_o, // Memory request, held until acknowledged
	output logic mem_we_o, // Memory write
	output logic [27:0] mem_addr_o, // Memory word address
	output logic [3:0] mem_be_o, // Memory byte enables
	output logic [31:0] mem_wdata_o, // Memory write word
	input wire logic [31:0] mem_rdata_i, // Memory read word
	input wire logic mem_ack_i, // Memory transfer done, one-cycle pulse
	output logic [DLY_W-1:0] dly_lane0_o, // Lane 0 read strobe delay
	output logic [DLY_W-1:0] dly_lane1_o, // Lane 1 read strobe delay
	output logic lane_count_sel_o // 0 one lane, 1 two lanes
);

	// ************************************************************
	// Declarations
	// ************************************************************
	ddrc_pkg::ddrc_state_t state;
	logic [ddrc_pkg::CFG_W-1:0] cfg;
	logic init_request;
	logic init_done;
	logic cor_stk;
	logic uncor_stk;
	logic ecc_acc;
	logic half;
	logic [15:0] wdata_hi;
	logic [15:0] rd_lo;
	logic cor_t;
	logic uncor_t;
	logic at_max;
	logic [2*DLY_W-1:0] dly;
	logic req_new;
	logic in_reg;
	logic reg_ok;
	logic in_mem;
	logic [31:0] mem_off;
	logic [31:0] win_lim;
	logic [31:0] reg_rd;
	logic [31:0] dly_word;
	logic dly_wr;
	logic cor_now;
	logic uncor_now;
	logic fwd_now;

	ddrc_ecc_if ecc (.clk(clk_i), .rst(rst_i));

	ddrc_ecc_codec u_codec (
		.e(ecc.codec)
	);

	ddrc_dly_bank #(.LANES(ddrc_pkg::LANES), .DLY_W(DLY_W)) u_dly (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(dly_wr),
		.sel_i(sel_i[1:0]),
		.wdata_i(dat_i[15:0]),
		.dly_o(dly),
		.at_max_o(at_max)
	);

	function automatic logic is_off(input logic [31:0] a, input logic [3:0] off);
		is_off = (a[31:4] == ddrc_pkg::REG_BASE[31:4]) && (a[3:0] == off);
	endfunction : is_off

	// ************************************************************
	// Address decode
	// ************************************************************
	assign req_new = cyc_i && stb_i && !ack_o && !err_o && (state == ddrc_pkg::ST_IDLE);
	assign in_reg = adr_i[31:4] == ddrc_pkg::REG_BASE[31:4];
	assign reg_ok = is_off(adr_i, ddrc_pkg::OFF_CFG) || is_off(adr_i, ddrc_pkg::OFF_DLY)
		|| is_off(adr_i, ddrc_pkg::OFF_STAT) || is_off(adr_i, ddrc_pkg::OFF_CTRL);
	assign mem_off = adr_i - ddrc_pkg::MEM_BASE;
	// Extended map doubles the window; ECC halves what software sees
	assign win_lim = cfg[ddrc_pkg::CFG_ECC]
		? ((cfg[ddrc_pkg::CFG_EXT] ? ddrc_pkg::MAP_EXT_BYTES : ddrc_pkg::MAP_STD_BYTES) >> 1)
		: (cfg[ddrc_pkg::CFG_EXT] ? ddrc_pkg::MAP_EXT_BYTES : ddrc_pkg::MAP_STD_BYTES);
	assign in_mem = (adr_i >= ddrc_pkg::MEM_BASE) && (mem_off < win_lim);
	assign dly_wr = req_new && we_i && is_off(adr_i, ddrc_pkg::OFF_DLY);

	always_comb begin
		dly_word = 32'h0000_0000;
		dly_word[DLY_W-1:0] = dly[DLY_W-1:0];
		dly_word[ddrc_pkg::DLY_SLOT +: DLY_W] = dly[DLY_W +: DLY_W];
	end

	always_comb begin
		reg_rd = 32'h0000_0000;
		case (adr_i[3:0])
			ddrc_pkg::OFF_CFG: reg_rd[ddrc_pkg::CFG_W-1:0] = cfg;
			ddrc_pkg::OFF_DLY: reg_rd = dly_word;
			ddrc_pkg::OFF_STAT: reg_rd[3:0] = {uncor_stk, cor_stk, at_max, init_done};
			ddrc_pkg::OFF_CTRL: reg_rd[ddrc_pkg::CTRL_INIT] = init_request;
			default: reg_rd = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// ECC path
	// ************************************************************
	// Only the upper half is ever re-issued from ST_MEM
	assign ecc.enc_data = (state == ddrc_pkg::ST_IDLE) ? dat_i[15:0] : wdata_hi;
	assign ecc.dec_word = mem_rdata_i;
	assign cor_now = ecc_acc && !mem_we_o && ecc.dec_single;
	assign uncor_now = ecc_acc && !mem_we_o && ecc.dec_double;
	assign fwd_now = ((uncor_t || uncor_now) && cfg[ddrc_pkg::CFG_ERR_FWD])
		|| ((cor_t || cor_now) && cfg[ddrc_pkg::CFG_COR_FWD]);

	// ************************************************************
	// Configuration, control and status
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= ddrc_pkg::CFG_RST;
		end else if (req_new && we_i && sel_i[0] && is_off(adr_i, ddrc_pkg::OFF_CFG)) begin
			cfg <= dat_i[ddrc_pkg::CFG_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_request <= 1'b0;
			init_done <= 1'b0;
		end else if (init_request && mem_init_done_i) begin
			init_request <= 1'b0;
			init_done <= 1'b1;
		end else if (req_new && we_i && sel_i[0] && is_off(adr_i, ddrc_pkg::OFF_CTRL)
			&& dat_i[ddrc_pkg::CTRL_INIT]) begin
			init_request <= 1'b1;
		end
	end

	// Sticky error flags; write one to clear, a fresh event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cor_stk <= 1'b0;
			uncor_stk <= 1'b0;
		end else begin
			cor_stk <= (cor_stk && !(req_new && we_i && sel_i[0]
				&& is_off(adr_i, ddrc_pkg::OFF_STAT) && dat_i[ddrc_pkg::STAT_COR]))
				|| (state == ddrc_pkg::ST_MEM && mem_ack_i && cor_now);
			uncor_stk <= (uncor_stk && !(req_new && we_i && sel_i[0]
				&& is_off(adr_i, ddrc_pkg::OFF_STAT) && dat_i[ddrc_pkg::STAT_UNCOR]))
				|| (state == ddrc_pkg::ST_MEM && mem_ack_i && uncor_now);
		end
	end

	assign dly_lane0_o = dly[DLY_W-1:0];
	assign dly_lane1_o = dly[DLY_W +: DLY_W];
	assign mem_init_o = init_request;
	assign lane_count_sel_o = cfg[ddrc_pkg::CFG_LANE];

	// ************************************************************
	// Bus and memory sequencer
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ddrc_pkg::ST_IDLE;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 28'h000_0000;
			mem_be_o <= 4'h0;
			mem_wdata_o <= 32'h0000_0000;
			ecc_acc <= 1'b0;
			half <= 1'b0;
			wdata_hi <= 16'h0000;
			rd_lo <= 16'h0000;
			cor_t <= 1'b0;
			uncor_t <= 1'b0;
		end else begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			case (state)
				ddrc_pkg::ST_IDLE: begin
					if (req_new && in_reg) begin
						ack_o <= reg_ok;
						err_o <= !reg_ok;
						dat_o <= reg_rd;
					end else if (req_new && in_mem && init_done) begin
						state <= ddrc_pkg::ST_MEM;
						mem_req_o <= 1'b1;
						mem_we_o <= we_i;
						ecc_acc <= cfg[ddrc_pkg::CFG_ECC];
						half <= 1'b0;
						wdata_hi <= dat_i[31:16];
						cor_t <= 1'b0;
						uncor_t <= 1'b0;
						if (cfg[ddrc_pkg::CFG_ECC]) begin
							mem_addr_o <= {mem_off[28:2], 1'b0};
							mem_wdata_o <= ecc.enc_word;
							mem_be_o <= {sel_i[1], sel_i[1], sel_i[0], sel_i[0]};
						end else begin
							mem_addr_o <= mem_off[29:2];
							mem_wdata_o <= dat_i;
							mem_be_o <= sel_i;
						end
					end else if (req_new) begin
						err_o <= 1'b1;
					end
				end
				ddrc_pkg::ST_MEM: begin
					if (mem_ack_i && ecc_acc && !half) begin
						// Second memory word carries the upper two data bytes
						half <= 1'b1;
						mem_addr_o <= mem_addr_o + 28'h000_0001;
						mem_wdata_o <= ecc.enc_word;
						mem_be_o <= {sel_i[3], sel_i[3], sel_i[2], sel_i[2]};
						rd_lo <= ecc.dec_data;
						cor_t <= cor_now;
						uncor_t <= uncor_now;
					end else if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						state <= ddrc_pkg::ST_RESP;
						dat_o <= ecc_acc ? {ecc.dec_data, rd_lo} : mem_rdata_i;
						err_o <= fwd_now;
						ack_o <= !fwd_now;
					end
				end
				ddrc_pkg::ST_RESP: begin
					state <= ddrc_pkg::ST_IDLE;
				end
				default: begin
					state <= ddrc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	AST_NO_MEM_BEFORE_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !in_reg && !init_done |=> err_o && !ack_o ##1 !mem_req_o)
		else $error("memory reached before init done");
	AST_ECC_HALF_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && init_done && cfg[ddrc_pkg::CFG_ECC] && !cfg[ddrc_pkg::CFG_EXT]
		&& adr_i == 32'h2000_0000 + 32'h1000_0000 |=> err_o && !mem_req_o)
		else $error("upper half visible with ECC");
	// Either half of the word may carry the fault, so the first half's flag counts too
	AST_UNCOR_FORWARD: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ddrc_pkg::ST_MEM && mem_ack_i && ecc_acc && half && !mem_we_o
		&& (ecc.dec_double || uncor_t) && cfg[ddrc_pkg::CFG_ERR_FWD]
		|=> err_o && !ack_o && uncor_stk)
		else $error("uncorrectable error not forwarded");
	AST_EXT_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && init_done && cfg[ddrc_pkg::CFG_EXT] && !cfg[ddrc_pkg::CFG_ECC]
		&& adr_i == 32'h4000_0000 |=> mem_req_o && mem_addr_o == 28'h800_0000)
		else $error("extended map not reached");
	AST_INIT_HANDSHAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(init_done) |-> $fell(init_request) && mem_init_o == 1'b0)
		else $error("init done without request clearing");
	AST_DLY_NEXT_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		dly_wr && sel_i[0] |=> dly_lane0_o == $past(dat_i[DLY_W-1:0]))
		else $error("delay write not applied");
	AST_COR_FORWARD: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ddrc_pkg::ST_MEM && mem_ack_i && ecc_acc && half && !mem_we_o
		&& (ecc.dec_single || cor_t) && cfg[ddrc_pkg::CFG_COR_FWD]
		|=> err_o && !ack_o && cor_stk)
		else $error("corrected error not forwarded");
	AST_ECC_LANES: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && in_mem && init_done && we_i && cfg[ddrc_pkg::CFG_ECC]
		|=> mem_req_o && mem_wdata_o[7:0] == $past(dat_i[7:0])
		&& mem_wdata_o[23:16] == $past(dat_i[15:8]))
		else $error("data byte written off its lane");

endmodule : ddrc_ctrl
`default_nettype wire

// ==== tb/ddrc_mem_model.sv ====
// Behavioural DDR memory with a read strobe window on each byte lane
`timescale 1ns/1ps
`default_nettype none
module ddrc_mem_model #(
	parameter int LO0 = 5, // Lane 0 first good delay
	parameter int HI0 = 9, // Lane 0 last good delay
	parameter int LO1 = 11, // Lane 1 first good delay
	parameter int HI1 = 14 // Lane 1 last good delay
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic req_i, // Request, held until ack
	input wire logic we_i, // Write
	input wire logic [27:0] addr_i, // Word address
	input wire logic [3:0] be_i, // Byte enables
	input wire logic [31:0] wdata_i, // Write word
	input wire logic [5:0] dly0_i, // Lane 0 strobe delay
	input wire logic [5:0] dly1_i, // Lane 1 strobe delay
	output logic [31:0] rdata_o, // Read word
	output logic ack_o // One-cycle acknowledge
);
	logic [31:0] mem [64];
	logic [31:0] rd;
	logic [7:0] b;
	int cnt;
	int d;
	int lat = 2;

	// Released data lines toggle, so stale data never looks valid
	always @(posedge clk_i) begin
		rd = ~rdata_o;
		ack_o <= 1'b0;
		if (rst_i) begin
			rd = 32'h5a5a_a5a5;
			cnt <= 0;
		end else if (req_i && ack_o !== 1'b1) begin
			if (cnt < lat) begin
				cnt <= cnt + 1;
			end else begin
				cnt <= 0;
				ack_o <= 1'b1;
				for (int i = 0; i < 4; i++) begin
					d = (i % 2 == 1) ? dly1_i : dly0_i;
					b = mem[addr_i[5:0]][8*i +: 8];
					if (we_i && be_i[i]) begin
						mem[addr_i[5:0]][8*i +: 8] = wdata_i[8*i +: 8];
					end
					// Early strobe samples junk, a late one the next, all-zero beat
					if (d < ((i % 2 == 1) ? LO1 : LO0)) begin
						b = b ^ 8'h3c;
					end else if (d > ((i % 2 == 1) ? HI1 : HI0)) begin
						b = 8'h00;
					end
					rd[8*i +: 8] = b;
				end
			end
		end
		rdata_o <= rd;
	end
endmodule : ddrc_mem_model
`default_nettype wire

// ==== tb/test_ddr_read_calibration_ecc.sv ====
// Self-checking bench: init, strobe calibration, ECC and memory window over Wishbone
`timescale 1ns/1ps
`default_nettype none
module test_ddr_read_calibration_ecc;
	localparam logic [31:0] CFG = ddrc_pkg::REG_BASE + 32'(ddrc_pkg::OFF_CFG);
	localparam logic [31:0] DLY = ddrc_pkg::REG_BASE + 32'(ddrc_pkg::OFF_DLY);
	localparam logic [31:0] STAT = ddrc_pkg::REG_BASE + 32'(ddrc_pkg::OFF_STAT);
	localparam logic [31:0] CTRL = ddrc_pkg::REG_BASE + 32'(ddrc_pkg::OFF_CTRL);
	localparam logic [31:0] MEM = ddrc_pkg::MEM_BASE;
	localparam logic [31:0] B_LANE = 32'h1 << ddrc_pkg::CFG_LANE;
	localparam logic [31:0] B_ECC = 32'h1 << ddrc_pkg::CFG_ECC;
	localparam logic [31:0] B_COR = 32'h1 << ddrc_pkg::CFG_COR_FWD;
	localparam logic [31:0] B_UNC = 32'h1 << ddrc_pkg::CFG_ERR_FWD;
	localparam logic [31:0] B_EXT = 32'h1 << ddrc_pkg::CFG_EXT;
	localparam logic [7:0] FIN0 = 8'h07;
	localparam logic [7:0] FIN1 = 8'h0c;

	logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, err_o, mem_init_o, mem_init_done_i;
	logic [31:0] adr_i, dat_i, dat_o, mem_wdata_o, mem_rdata_i, rd;
	logic [3:0] sel_i, mem_be_o;
	logic mem_req_o, mem_we_o, mem_ack_i, lane_count_sel_o, e, chg;
	logic [27:0] mem_addr_o;
	logic [5:0] dly_lane0_o, dly_lane1_o;
	logic [7:0] dl [2];
	int errors, num_checks;

	ddrc_ctrl i_ddrc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .err_o(err_o), .mem_init_o(mem_init_o),
		.mem_init_done_i(mem_init_done_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .dly_lane0_o(dly_lane0_o),
		.dly_lane1_o(dly_lane1_o), .lane_count_sel_o(lane_count_sel_o));

	ddrc_mem_model i_ddrc_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o),
		.dly0_i(dly_lane0_o), .dly1_i(dly_lane1_o), .rdata_o(mem_rdata_i),
		.ack_o(mem_ack_i));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic wrap_up();
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; the slave alone decides when it answers
	task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic w);
		int n;
		@(posedge clk_i);
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		we_i <= w;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1 || err_o === 1'b1) begin
				break;
			end
		end
		rd = dat_o;
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n == 200) begin
			errors++;
			wrap_up();
		end
	endtask : wb

	// One calibration phase: bump each lane until its test byte reads tgt
	task automatic calib(input int nl, input logic [7:0] tgt);
		logic [3:0] s;
		s = (nl == 1) ? 4'h1 : 4'h3;
		chg = 1'b1;
		while (chg) begin
			wb(MEM, 32'h0, s, 1'b0);
			chg = 1'b0;
			for (int l = 0; l < nl; l++) begin
				if (rd[8*l +: 8] !== tgt) begin
					if (dl[l] == 8'h3f) begin
						errors++;
						wrap_up();
					end
					dl[l] = dl[l] + 8'h01;
					chg = 1'b1;
				end
			end
			if (chg) begin
				wb(DLY, {16'h0, dl[1], dl[0]}, s, 1'b1);
			end
		end
	endtask : calib

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_i = 1'b1;
		{adr_i, dat_i, sel_i, we_i, cyc_i, stb_i, mem_init_done_i} = '0;
		errors = 0;
		num_checks = 0;
		dl[0] = 8'h00;
		dl[1] = 8'h00;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'({mem_req_o, mem_init_o, dly_lane1_o, dly_lane0_o, lane_count_sel_o}), 0);
		wb(CFG, 0, 4'hf, 1'b0);
		chk(rd, 32'(ddrc_pkg::CFG_RST));
		wb(ddrc_pkg::REG_BASE + 32'h10, 0, 4'hf, 1'b0);
		chk(32'(e), 1);
		wb(MEM, 32'hff, 4'hf, 1'b1);
		chk(32'(e), 1);
		wb(CTRL, 1, 4'hf, 1'b1);
		for (int n = 0; n < 5 && mem_init_o !== 1'b1; n++) @(posedge clk_i);
		chk(32'(mem_init_o), 1);
		mem_init_done_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'(mem_init_o), 0);
		wb(STAT, 0, 4'hf, 1'b0);
		chk(rd, 32'h1);
		wb(CTRL, 0, 4'hf, 1'b0);
		chk(rd[0], 0);
		// One lane
		wb(MEM, 32'hff, 4'hf, 1'b1);
		chk(32'(e), 0);
		wb(DLY, 0, 4'h3, 1'b1);
		calib(1, 8'hff);
		calib(1, 8'h00);
		dl[0] = dl[0] - 8'h03;
		wb(DLY, {16'h0, dl[1], dl[0]}, 4'h1, 1'b1);
		chk(32'(dly_lane0_o), 32'(FIN0));
		wb(MEM, 0, 4'h1, 1'b0);
		chk(rd[7:0], 8'hff);
		// Two lanes
		wb(CFG, B_LANE, 4'hf, 1'b1);
		chk(32'(lane_count_sel_o), 1);
		wb(MEM, 32'hffff, 4'hf, 1'b1);
		wb(MEM + 4, 0, 4'hf, 1'b1);
		dl[0] = 8'h00;
		dl[1] = 8'h00;
		wb(DLY, 0, 4'h3, 1'b1);
		calib(2, 8'hff);
		calib(2, 8'h00);
		dl[0] = dl[0] - 8'h03;
		dl[1] = dl[1] - 8'h03;
		wb(DLY, {16'h0, dl[1], dl[0]}, 4'h3, 1'b1);
		wb(DLY, 0, 4'hf, 1'b0);
		chk(rd, {16'h0, FIN1, FIN0});
		wb(DLY, 32'h3f, 4'h1, 1'b1);
		wb(STAT, 0, 4'hf, 1'b0);
		chk(rd[1], 1);
		wb(DLY, {16'h0, dl[1], dl[0]}, 4'h1, 1'b1);
		wb(STAT, 0, 4'hf, 1'b0);
		chk(rd[1], 0);
		// ECC
		i_ddrc_mem_model.lat = 0;
		wb(CFG, B_LANE | B_ECC, 4'hf, 1'b1);
		wb(MEM + 8, 32'h1234_5678, 4'hf, 1'b1);
		wb(MEM + 8, 0, 4'hf, 1'b0);
		chk(rd, 32'h1234_5678);
		chk({i_ddrc_mem_model.mem[5][23:16], i_ddrc_mem_model.mem[5][7:0],
			i_ddrc_mem_model.mem[4][23:16], i_ddrc_mem_model.mem[4][7:0]}, 32'h1234_5678);
		i_ddrc_mem_model.mem[4][0] = ~i_ddrc_mem_model.mem[4][0];
		wb(MEM + 8, 0, 4'hf, 1'b0);
		chk({rd[30:0], e}, {31'h1234_5678, 1'b0});
		wb(STAT, 0, 4'hf, 1'b0);
		chk(rd[3:2], 2'b01);
		wb(STAT, 32'hc, 4'hf, 1'b1);
		wb(CFG, B_LANE | B_ECC | B_COR, 4'hf, 1'b1);
		wb(MEM + 8, 0, 4'hf, 1'b0);
		chk({rd[30:0], e}, {31'h1234_5678, 1'b1});
		i_ddrc_mem_model.mem[4][1] = ~i_ddrc_mem_model.mem[4][1];
		wb(CFG, B_LANE | B_ECC | B_UNC, 4'hf, 1'b1);
		wb(MEM + 8, 0, 4'hf, 1'b0);
		chk(32'(e), 1);
		wb(CFG, B_LANE | B_ECC, 4'hf, 1'b1);
		wb(MEM + 8, 0, 4'hf, 1'b0);
		chk(32'(e), 0);
		wb(STAT, 0, 4'hf, 1'b0);
		chk(rd[3], 1);
		wb(32'h2fff_fffc, 32'h0, 4'hf, 1'b1);
		chk(32'(e), 0);
		// Visible window
		wb(32'h3000_0000, 0, 4'hf, 1'b0);
		chk(32'(e), 1);
		wb(CFG, B_LANE, 4'hf, 1'b1);
		wb(32'h4000_0000, 0, 4'hf, 1'b0);
		chk(32'(e), 1);
		wb(CFG, B_LANE | B_EXT, 4'hf, 1'b1);
		wb(32'h4000_0000, 0, 4'hf, 1'b0);
		chk(32'(e), 0);
		wrap_up();
	end
endmodule : test_ddr_read_calibration_ecc
`default_nettype wire
